// ==== hdl/dpsac_map.vh ====
// Purpose: constants for the dual-port sram access controller
// Assumes: 100 MHz clock, 10 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef DPSAC_MAP_VH
`define DPSAC_MAP_VH
`define DPSAC_CLK_NS 10
// least times round up to whole cycles, never below one
`define DPSAC_CYC_MIN(t) ((((t) + `DPSAC_CLK_NS - 1) / `DPSAC_CLK_NS) < 1 ? 1 : \
  (((t) + `DPSAC_CLK_NS - 1) / `DPSAC_CLK_NS))
// slower grade figures are used so either grade is served
`define DPSAC_T_RC_NS 20
`define DPSAC_T_WC_NS 20
`define DPSAC_T_WP_NS 15
`define DPSAC_T_EW_NS 15
`define DPSAC_T_AW_NS 15
`define DPSAC_T_DW_NS 15
`define DPSAC_T_WZ_NS 10
`define DPSAC_T_AA_NS 20
`define DPSAC_T_AOE_NS 12
`define DPSAC_T_HZ_NS 10
`define DPSAC_T_SOP_NS 10
`define DPSAC_T_SWRD_NS 5
`define DPSAC_T_SPS_NS 5
// access kinds on the command port
`define DPSAC_OP_READ 1'b0
`define DPSAC_OP_WRITE 1'b1
// semaphore flag index bits
`define DPSAC_SEM_IDX_W 3
`endif

// ==== hdl/dpsac_cnt.v ====
// Purpose: down counter that times one phase of a pin access
// Assumes: load and count from the same clock as the caller
// Notes: done is high while the count has reached zero
`timescale 1ns/1ps
module dpsac_cnt #(
  parameter W = 4
) (
  input wire clk,
  input wire arst_n,
  input wire load,
  input wire [W-1:0] value,
  output wire done
);
  reg [W-1:0] cnt_q; // remaining cycles
  // load wins over counting so a new phase starts cleanly
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done = (cnt_q == {W{1'b0}});
endmodule

// ==== hdl/dpsac_host.v ====
// Purpose: host-side controller driving one port of a dual-port static ram
// Assumes: single 100 MHz clock; data pins return through three flops
// Notes: one access at a time; a request is taken while REQ_READY is high
`timescale 1ns/1ps
`include "dpsac_map.vh"
module dpsac_host #(
  parameter AW = 16,
  parameter DW = 16,
  parameter CW = 4
) (
  input wire CLK,
  input wire ARST_N,
  input wire REQ_VALID,
  output wire REQ_READY,
  input wire REQ_WRITE,
  input wire REQ_SEM,
  input wire [AW-1:0] REQ_ADDR,
  input wire [DW-1:0] REQ_WDATA,
  input wire [1:0] REQ_BYTE_N,
  output reg RSP_VALID,
  output reg [DW-1:0] RSP_RDATA,
  output reg CHIP_SELECT_N,
  output reg RW_N,
  output reg OUTPUT_ENABLE_N,
  output reg UPPER_BYTE_SELECT_N,
  output reg LOWER_BYTE_SELECT_N,
  output reg SEMAPHORE_SELECT_N,
  output reg [AW-1:0] ADDR,
  output reg [DW-1:0] DATA_O,
  output reg DATA_OE_N,
  input wire [DW-1:0] DATA_I
);
  // phase lengths in whole cycles, worked out at integer width first
  localparam integer N_WP_RAW = `DPSAC_CYC_MIN(`DPSAC_T_WP_NS);
  localparam integer N_WZDW = `DPSAC_CYC_MIN(`DPSAC_T_WZ_NS + `DPSAC_T_DW_NS);
  localparam integer N_AW = `DPSAC_CYC_MIN(`DPSAC_T_AW_NS);
  localparam integer N_RD = `DPSAC_CYC_MIN(`DPSAC_T_AA_NS);
  localparam integer N_HZ = `DPSAC_CYC_MIN(`DPSAC_T_HZ_NS);
  localparam integer N_SOP = `DPSAC_CYC_MIN(`DPSAC_T_SOP_NS);
  localparam integer N_SWRD = `DPSAC_CYC_MIN(`DPSAC_T_SWRD_NS);
  // pulse is the larger of plain width, address window and turn-off plus set-up
  localparam integer N_WP_A = (N_WP_RAW > N_AW) ? N_WP_RAW : N_AW;
  localparam integer N_WP = (N_WP_A > N_WZDW) ? N_WP_A : N_WZDW;
  // timer loads cut to the timer width on purpose; every count fits in CW bits
  // a load of n holds its phase for n+1 cycles, a spare cycle of margin
  localparam [CW-1:0] C_WP = N_WP[CW-1:0];
  localparam [CW-1:0] C_RD = N_RD[CW-1:0];
  localparam [CW-1:0] C_HZ = N_HZ[CW-1:0];
  localparam [CW-1:0] C_SOP = N_SOP[CW-1:0];
  localparam [CW-1:0] C_SWRD = N_SWRD[CW-1:0];
  // states, one-hot
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_WPUL = 5'h02;
  localparam [4:0] S_RD = 5'h04;
  localparam [4:0] S_REC = 5'h08;
  localparam [4:0] S_SETUP = 5'h10;
  reg [4:0] state_q; // access sequencer state
  reg is_write_q; // current access is a write
  reg is_sem_q; // current access targets a flag
  reg last_sem_wr_q; // previous access was a flag write
  reg [DW-1:0] sync1_q; // data pin synchroniser, first stage
  reg [DW-1:0] sync2_q; // second stage
  reg [DW-1:0] sync3_q; // third stage, compared with second
  reg cnt_load; // start a phase timer
  reg [CW-1:0] cnt_value; // length of that phase
  wire cnt_done; // phase timer expired
  dpsac_cnt #(.W(CW)) u_cnt (
    .clk(CLK),
    .arst_n(ARST_N),
    .load(cnt_load),
    .value(cnt_value),
    .done(cnt_done)
  );
  // idle and timer done means the pins are back at rest
  assign REQ_READY = state_q[0] & cnt_done;
  // three-stage sync of the returning data; only stage two feeds stage three
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_q <= {DW{1'b0}};
      sync2_q <= {DW{1'b0}};
      sync3_q <= {DW{1'b0}};
    end else begin
      sync1_q <= DATA_I;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // timer loads chosen by state transitions
  always @* begin
    cnt_load = 1'b0;
    cnt_value = {CW{1'b0}};
    case (state_q)
      S_IDLE: begin
        if (REQ_VALID && cnt_done) begin
          cnt_load = 1'b1;
          cnt_value = {{(CW-1){1'b0}}, 1'b1};
        end
      end
      S_SETUP: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          cnt_value = is_write_q ? C_WP : C_RD;
        end
      end
      S_WPUL: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          cnt_value = is_sem_q ? ((C_SOP > C_SWRD) ? C_SOP : C_SWRD) : C_HZ;
        end
      end
      S_RD: begin
        if (cnt_done) begin
          cnt_load = 1'b1;
          cnt_value = is_sem_q ? C_SOP : C_HZ;
        end
      end
      S_REC: cnt_load = 1'b0;
      default: cnt_load = 1'b0;
    endcase
  end
  // sequencer and pin drive
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= S_IDLE;
      is_write_q <= 1'b0;
      is_sem_q <= 1'b0;
      last_sem_wr_q <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= {DW{1'b0}};
      CHIP_SELECT_N <= 1'b1;
      RW_N <= 1'b1;
      OUTPUT_ENABLE_N <= 1'b1;
      UPPER_BYTE_SELECT_N <= 1'b1;
      LOWER_BYTE_SELECT_N <= 1'b1;
      SEMAPHORE_SELECT_N <= 1'b1;
      ADDR <= {AW{1'b0}};
      DATA_O <= {DW{1'b0}};
      DATA_OE_N <= 1'b1;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // address moves only here, with all strobes high
          if (REQ_VALID && cnt_done) begin
            ADDR <= REQ_SEM ? {{(AW-`DPSAC_SEM_IDX_W){1'b0}}, REQ_ADDR[`DPSAC_SEM_IDX_W-1:0]}
                            : REQ_ADDR;
            is_write_q <= REQ_WRITE;
            is_sem_q <= REQ_SEM;
            // flag writes carry the request in bit zero on every pin
            DATA_O <= REQ_SEM ? {DW{REQ_WDATA[0]}} : REQ_WDATA;
            if (REQ_SEM) begin
              UPPER_BYTE_SELECT_N <= 1'b1;
              LOWER_BYTE_SELECT_N <= 1'b1;
            end else begin
              UPPER_BYTE_SELECT_N <= REQ_BYTE_N[1];
              LOWER_BYTE_SELECT_N <= REQ_BYTE_N[0];
            end
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          // address has stood two cycles; now open the access
          if (cnt_done) begin
            CHIP_SELECT_N <= is_sem_q;
            SEMAPHORE_SELECT_N <= ~is_sem_q;
            if (is_write_q) begin
              // strobe falls with select, so output enable stays high
              RW_N <= 1'b0;
              DATA_OE_N <= 1'b0;
              state_q <= S_WPUL;
            end else begin
              OUTPUT_ENABLE_N <= 1'b0;
              state_q <= S_RD;
            end
          end
        end
        S_WPUL: begin
          // strobe and select rise together; data held one more edge
          if (cnt_done) begin
            RW_N <= 1'b1;
            CHIP_SELECT_N <= 1'b1;
            SEMAPHORE_SELECT_N <= 1'b1;
            last_sem_wr_q <= is_sem_q;
            state_q <= S_REC;
          end
        end
        S_RD: begin
          // sample at the end, from stage two, which holds the pins as taken one edge after output enable fell
          if (cnt_done) begin
            RSP_RDATA <= (sync2_q == sync3_q) ? sync3_q : sync2_q;
            RSP_VALID <= 1'b1;
            OUTPUT_ENABLE_N <= 1'b1;
            CHIP_SELECT_N <= 1'b1;
            SEMAPHORE_SELECT_N <= 1'b1;
            last_sem_wr_q <= 1'b0;
            state_q <= S_REC;
          end
        end
        S_REC: begin
          // drive released after the edge the strobes rose; hold time met
          DATA_OE_N <= 1'b1;
          UPPER_BYTE_SELECT_N <= 1'b1;
          LOWER_BYTE_SELECT_N <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ==== tb/dpsac_chk.sv ====
// Purpose: pin timing checks on the host controller
// Assumes: one clock, async active-low reset
// Notes: each documented time is counted in whole 10 ns cycles
`timescale 1ns/1ps
module dpsac_chk (
  input wire CLK,
  input wire ARST_N,
  input wire RSP_VALID,
  input wire CHIP_SELECT_N,
  input wire RW_N,
  input wire OUTPUT_ENABLE_N,
  input wire UPPER_BYTE_SELECT_N,
  input wire LOWER_BYTE_SELECT_N,
  input wire SEMAPHORE_SELECT_N,
  input wire [15:0] ADDR,
  input wire DATA_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  chk_sel_excl: assert property (CHIP_SELECT_N || SEMAPHORE_SELECT_N)
    else $error("array and flag selects low together");
  chk_flag_bytes: assert property (!SEMAPHORE_SELECT_N |-> UPPER_BYTE_SELECT_N && LOWER_BYTE_SELECT_N)
    else $error("byte select low during flag access");
  chk_addr_hold: assert property (!$stable(ADDR) |-> RW_N && $past(RW_N))
    else $error("address moved during write strobe");
  chk_wp_width: assert property ($fell(RW_N) |=> !RW_N)
    else $error("write pulse shorter than two cycles");
  chk_wr_oe: assert property (!RW_N |-> OUTPUT_ENABLE_N)
    else $error("output enable low during write");
  chk_wr_data: assert property ($rose(RW_N) |-> !DATA_OE_N && !$past(DATA_OE_N, 2))
    else $error("write data not driven around write end");
  chk_wr_addr: assert property ($rose(RW_N) |-> ADDR == $past(ADDR, 2))
    else $error("address not valid before write end");
  chk_wr_sel: assert property ($rose(RW_N) |-> !$past(CHIP_SELECT_N, 2) || !$past(SEMAPHORE_SELECT_N, 2))
    else $error("select too short before write end");
  chk_rd_len: assert property ($fell(OUTPUT_ENABLE_N) |-> !OUTPUT_ENABLE_N [*2])
    else $error("read cycle too short");
  chk_rd_rsp: assert property ($fell(OUTPUT_ENABLE_N) |-> ##3 RSP_VALID)
    else $error("read answer not three cycles after enable");
  cover property ($fell(RW_N) && !CHIP_SELECT_N);
  cover property ($fell(RW_N) && !SEMAPHORE_SELECT_N);
  cover property (RSP_VALID);
endmodule
bind dpsac_host dpsac_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .RSP_VALID(RSP_VALID),
  .CHIP_SELECT_N(CHIP_SELECT_N), .RW_N(RW_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N),
  .UPPER_BYTE_SELECT_N(UPPER_BYTE_SELECT_N), .LOWER_BYTE_SELECT_N(LOWER_BYTE_SELECT_N),
  .SEMAPHORE_SELECT_N(SEMAPHORE_SELECT_N), .ADDR(ADDR), .DATA_OE_N(DATA_OE_N));

// ==== tb/dpsac_ram.sv ====
// Purpose: behavioural model of one port of the dual-port ram
// Assumes: no clock on the device side, delays in ns
// Notes: a floating bus shows the inverse word, so a word never written floats as unknown
`timescale 1ns/1ps
module dpsac_ram (
  input wire cs_n,
  input wire rw_n,
  input wire oe_n,
  input wire ub_n,
  input wire lb_n,
  input wire sem_n,
  input wire [15:0] addr,
  input wire [15:0] din,
  input wire din_oe_n,
  output wire [15:0] dout
);
  reg [15:0] mem [0:65535]; // array words
  reg [7:0] flag = 8'hff; // flags start free
  wire nb = ub_n && lb_n; // no byte lane selected
  wire fsel = !sem_n && (cs_n || nb); // flag space reached
  wire [15:0] d = din_oe_n ? ~din : din; // undriven bus stores garbage
  // no drive while the strobe is low, so write data never meets our output
  wire rd = !oe_n && rw_n && (fsel || (!cs_n && sem_n && !nb));
  wire [15:0] v = fsel ? {16{flag[addr[2:0]]}} : mem[addr];
  // one port only, so no busy delay; the inertial delay keeps old data past 3 ns
  assign #10 dout = rd ? v : ~v;
  // storing follows the overlap, so a short overlap is caught on read-back
  always @* begin
    // storing stops at the first of select or strobe to rise
    if (!cs_n && sem_n && !rw_n && !ub_n) mem[addr][15:8] = d[15:8];
    if (!cs_n && sem_n && !rw_n && !lb_n) mem[addr][7:0] = d[7:0];
    if (fsel && !rw_n) flag[addr[2:0]] = d[0];
  end
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the host controller
// Assumes: 100 MHz clock, inputs driven 1 ns after each rising edge
// Notes: rows hold write, flag, address, data, byte selects, read result
`timescale 1ns/1ps
module tb;
  logic clk = 0, arst_n = 0, req_valid = 0, req_write = 0, req_sem = 0;
  logic [15:0] req_addr = 0, req_wdata = 0;
  logic [1:0] req_byte_n = 0;
  wire req_ready, rsp_valid, cs_n, rw_n, oe_n, ub_n, lb_n, sem_n, data_oe_n;
  wire [15:0] rsp_rdata, addr, data_o, data_i;
  int bad_count = 0, total_checks = 0, cyc = 0;
  logic [51:0] rows [0:14];
  dpsac_host DUT (.CLK(clk), .ARST_N(arst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_WRITE(req_write), .REQ_SEM(req_sem), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_BYTE_N(req_byte_n), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .CHIP_SELECT_N(cs_n),
    .RW_N(rw_n), .OUTPUT_ENABLE_N(oe_n), .UPPER_BYTE_SELECT_N(ub_n), .LOWER_BYTE_SELECT_N(lb_n),
    .SEMAPHORE_SELECT_N(sem_n), .ADDR(addr), .DATA_O(data_o), .DATA_OE_N(data_oe_n), .DATA_I(data_i));
  dpsac_ram u_ram (.cs_n(cs_n), .rw_n(rw_n), .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .sem_n(sem_n),
    .addr(addr), .din(data_o), .din_oe_n(data_oe_n), .dout(data_i));
  initial forever #5 clk = ~clk;
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // strobes all high and no answer while reset holds
  task rst_chk;
    chk("pins", 16'({cs_n, rw_n, oe_n, ub_n, lb_n, sem_n, data_oe_n}), 16'h007f);
    chk("rsp", 16'(rsp_valid), 16'h0000);
  endtask
  // one request; a read is answered exactly five edges after the take
  task req(input logic [51:0] r);
    {req_write, req_sem, req_addr, req_wdata, req_byte_n} = r[51:16];
    req_valid = 1;
    while (req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    req_valid = 0;
    chk("busy", 16'(req_ready), 16'h0000);
    if (!r[51]) begin
      repeat (5) @(posedge clk);
      #1 chk("rsp", 16'(rsp_valid), 16'h0001);
      chk("rdata", rsp_rdata, r[15:0]);
    end
    @(posedge clk) #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  initial begin
    rows = '{{2'b10, 16'h0001, 16'ha5a5, 2'b00, 16'h0000}, {2'b00, 16'h0001, 16'h0000, 2'b00, 16'ha5a5},
      {2'b10, 16'h0002, 16'hffff, 2'b00, 16'h0000}, {2'b10, 16'h0002, 16'h0012, 2'b10, 16'h0000},
      {2'b00, 16'h0002, 16'h0000, 2'b00, 16'hff12}, {2'b10, 16'hffff, 16'h5a5a, 2'b00, 16'h0000},
      {2'b00, 16'hffff, 16'h0000, 2'b00, 16'h5a5a}, {2'b11, 16'h000d, 16'hfffe, 2'b11, 16'h0000},
      {2'b11, 16'h0005, 16'h0001, 2'b11, 16'h0000}, {2'b01, 16'h0005, 16'h0000, 2'b11, 16'hffff},
      {2'b11, 16'h000b, 16'hfffe, 2'b11, 16'h0000}, {2'b01, 16'h0003, 16'h0000, 2'b11, 16'h0000},
      {2'b00, 16'h0001, 16'h0000, 2'b00, 16'ha5a5},
      {2'b10, 16'hffff, 16'h0000, 2'b01, 16'h0000}, {2'b00, 16'hffff, 16'h0000, 2'b00, 16'h005a}};
    repeat (20) @(posedge clk);
    #1 rst_chk();
    arst_n = 1;
    for (int i = 0; i < 15; i++) req(rows[i]);
    // reset lands while select and output enable are low; pins must drop back at once
    {req_write, req_sem, req_addr} = {2'b00, 16'h0002};
    req_valid = 1;
    repeat (3) @(posedge clk) #1;
    arst_n = 0;
    req_valid = 0;
    #1 rst_chk();
    chk("addr", addr, 16'h0000);
    repeat (2) @(posedge clk) #1;
    arst_n = 1;
    req(rows[4]);
    finish_test();
  end
endmodule
